// >>> testbench/visq_cpu_model.sv
// Purpose: CPU sequencer model presenting instruction words
// Assumes: Word held until the sequencer executes it
// Notes:   Released word is inverted so no stale value shows
`timescale 1ns/1ns
module visq_cpu_model
  import visq_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Bench side
  input  wire logic                  go_i,
  input  wire visq_pkg::visq_instr_t ins_i,
  output logic                       done_o,
  // Sequencer side
  input  wire logic                  instr_ack_i,
  output logic                       instr_valid_o,
  output visq_pkg::visq_instr_t      instr_o
);
  // Word held across an entry executes as the first word at the vector
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      instr_valid_o <= 1'b0;
      instr_o       <= '0;
    end
    else if (go_i)
    begin
      instr_valid_o <= 1'b1;
      instr_o       <= ins_i;
    end
    else if (instr_valid_o && instr_ack_i)
    begin
      instr_valid_o <= 1'b0;
      instr_o       <= ~instr_o;
      done_o        <= 1'b1;
    end
  end
endmodule : visq_cpu_model

// >>> testbench/visq_sequencer_chk.sv
// Purpose: Port assertions of the interrupt sequencer
// Assumes: Bound to visq_sequencer, one clock domain
// Notes:   Watches outputs against their causes
`timescale 1ns/1ns
module visq_sequencer_chk
  import visq_pkg::*;
(
  // Watched ports
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  instr_ack_o,
  input wire visq_pkg::visq_instr_t instr_i,
  input wire logic [PC_W-1:0]       pc_o,
  input wire visq_pkg::visq_ctx_t   ctx_i,
  input wire visq_pkg::visq_ctx_t   ctx_o,
  input wire logic                  global_irq_enable_o,
  input wire logic                  irq_taken_o
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_in_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  taken_needs_enable_a: assert property (irq_taken_o |-> $past(global_irq_enable_o))
    else $error("entry without enable");
  taken_clears_enable_a: assert property (irq_taken_o |-> !global_irq_enable_o)
    else $error("enable kept on entry");
  vector_addr_a: assert property (irq_taken_o |->
    pc_o inside {14'h0080, 14'h0084, 14'h0086, 14'h0088})
    else $error("bad vector");
  ctx_saved_a: assert property (irq_taken_o |-> ctx_o == $past(ctx_i))
    else $error("context not saved");
  pc_step_a: assert property (instr_ack_o
    && !(instr_i.branch || instr_i.call || instr_i.ret
    || instr_i.return_from_irq_instr || instr_i.skip_test)
    |=> pc_o == $past(pc_o) + 14'h0001)
    else $error("pc step wrong");
  branch_load_a: assert property (instr_ack_o && instr_i.branch
    |=> pc_o == $past(instr_i.target))
    else $error("branch target wrong");
  enable_delay_a: assert property (instr_ack_o && instr_i.enable_irq_instr
    && !global_irq_enable_o |=> !global_irq_enable_o)
    else $error("enable too early");
  disable_now_a: assert property (instr_ack_o && instr_i.disable_irq_instr
    |=> !global_irq_enable_o)
    else $error("disable ignored");
  step_spacing_a: assert property (instr_ack_o |=> !instr_ack_o [*2])
    else $error("steps too close");
endmodule : visq_sequencer_chk

bind visq_sequencer visq_sequencer_chk visq_sequencer_chk_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .instr_ack_o, .instr_i, .pc_o, .ctx_i, .ctx_o,
  .global_irq_enable_o, .irq_taken_o);

// >>> testbench/visq_sequencer_tb.sv
// Purpose: Self-checking bench of the interrupt sequencer
// Assumes: Wishbone master and CPU model move on rising edges
// Notes:   Expectations from package constants
`timescale 1ns/1ns
module visq_sequencer_tb;
  import visq_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, done;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        instr_valid_i, instr_ack_o, skip_o, irq_taken_o, irq_o, gie, restore;
  logic        ext_irq_pin_i = 1'b0, vdrop_cond_i = 1'b0;
  logic [2:0]  tmr_uflow_i = 3'h0;
  logic [13:0] pc_o, p;
  visq_instr_t instr_i, op = '0;
  visq_ctx_t   ctx_i = '0, ctx_o;
  int          miscompares = 0, checks_done = 0;
  logic [6:0]  vec [4] = '{VEC_OFS_EXT, VEC_OFS_TA, VEC_OFS_TB, VEC_OFS_TC};

  always #50 clk_i = ~clk_i;

  visq_sequencer visq_sequencer_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_valid_i, .instr_i, .instr_ack_o,
    .pc_o, .skip_result_o(skip_o), .ctx_i, .ctx_o, .ctx_restore_o(restore), .ext_irq_pin_i,
    .tmr_uflow_i, .vdrop_cond_i, .global_irq_enable_o(gie), .irq_taken_o, .irq_o);
  visq_cpu_model visq_cpu_model_i (.clk_i, .rst_i, .go_i(go), .ins_i(op), .done_o(done),
    .instr_ack_i(instr_ack_o), .instr_valid_o(instr_valid_i), .instr_o(instr_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk

  task automatic wait_for(input bit irq);
    do
      @(posedge clk_i);
    while ((irq ? irq_taken_o : done) !== 1'b1);
  endtask : wait_for

  task automatic issue(input visq_instr_t i);
    @(posedge clk_i);
    op <= i;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : issue

  task automatic exec(input visq_instr_t i);
    issue(i);
    wait_for(1'b0);
  endtask : exec

  function automatic visq_instr_t mk(input int k, input logic [13:0] t);
    mk = '0;
    mk.target = t;
    mk.skip_src = t[1:0];
    mk.enable_irq_instr = (k == 1);
    mk.disable_irq_instr = (k == 2);
    mk.return_from_irq_instr = (k == 3);
    mk.branch = (k == 4);
    mk.skip_test = (k == 5);
    mk.call = (k == 6);
    mk.ret = (k == 7);
  endfunction : mk

  task automatic ev(input logic [2:0] u, input logic pin);
    @(posedge clk_i);
    tmr_uflow_i   <= u;
    ext_irq_pin_i <= ext_irq_pin_i ^ pin;
    @(posedge clk_i);
    tmr_uflow_i <= 3'h0;
  endtask : ev

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int a = 0; a <= 24; a += 4)
      if (a != 12)
        rdchk(8'(a), 32'h0);
    wb(1'b1, ADDR_ENABLE, 32'hFF);
    rdchk(ADDR_ENABLE, 32'hFF);
    wb(1'b1, ADDR_PC, 32'h3FFF);
    rdchk(ADDR_PC, 32'h0);
  endtask : t_regs

  task automatic t_flags;
    ev(3'h7, 1'b1);
    rdchk(ADDR_FLAGS, 32'h0F);
    @(posedge clk_i) vdrop_cond_i <= 1'b1;
    rdchk(ADDR_FLAGS, 32'h1F);
    wb(1'b1, ADDR_FLAGS, 32'h10);
    rdchk(ADDR_FLAGS, 32'h1F);
    @(posedge clk_i) vdrop_cond_i <= 1'b0;
    wb(1'b1, ADDR_FLAGS, 32'h10);
    rdchk(ADDR_FLAGS, 32'h0F);
  endtask : t_flags

  task automatic t_skip;
    wb(1'b1, ADDR_ENABLE, 32'h0);
    for (int s = 0; s < NSRC; s++)
    begin
      exec(mk(5, 14'(s)));
      chk(32'(skip_o), 32'h1);
      exec(mk(5, 14'(s)));
      chk(32'(skip_o), 32'h0);
    end
    wb(1'b1, ADDR_ENABLE, 32'h04);
    ev(3'h1, 1'b0);
    exec(mk(5, 14'h1));
    chk(32'(skip_o), 32'h0);
    rdchk(ADDR_FLAGS, 32'h02);
  endtask : t_skip

  task automatic t_pc;
    exec(mk(4, 14'h017F));
    chk(32'(pc_o), 32'h017F);
    exec(mk(0, 14'h0));
    chk(32'(pc_o), 32'h0180);
    exec(mk(6, 14'h0100));
    chk(32'(pc_o), 32'h0100);
    exec(mk(7, 14'h0));
    chk(32'(pc_o), 32'h0181);
  endtask : t_pc

  task automatic t_irq;
    wb(1'b1, ADDR_MASK, 32'hF);
    wb(1'b1, ADDR_ENABLE, 32'h1D);
    ev(3'h7, 1'b1);
    for (int s = 0; s < NSRC; s++)
    begin
      exec(mk(1, 14'h0));
      chk(32'(gie), 32'h0);
      exec(mk(0, 14'h0));
      chk(32'(gie), 32'h1);
      p = pc_o;
      ctx_i <= {16'h5A3C, 4'(s)};
      issue(mk(0, 14'h0));
      wait_for(1'b1);
      chk(32'(pc_o), 32'(VEC_PAGE_BASE) + 32'(vec[s]));
      chk(32'(gie), 32'h0);
      chk(32'(ctx_o), {12'h0, 16'h5A3C, 4'(s)});
      wait_for(1'b0);
      rdchk(ADDR_FLAGS, 32'h0F & (32'h0F << (s + 1)));
      chk(32'(irq_o), 32'h1);
      exec(mk(3, 14'h0));
      chk(32'(pc_o), 32'(p));
      chk(32'(restore), 32'h1);
    end
  endtask : t_irq

  task automatic t_mask;
    wb(1'b1, ADDR_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, ADDR_MASK, 32'hF);
    wb(1'b1, ADDR_STATUS, 32'h5);
    rdchk(ADDR_STATUS, 32'hA);
    wb(1'b1, ADDR_STATUS, 32'hA);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
  endtask : t_mask

  task automatic t_block;
    wb(1'b1, ADDR_ENABLE, 32'h0);
    ev(3'h4, 1'b0);
    exec(mk(1, 14'h0));
    exec(mk(0, 14'h0));
    exec(mk(0, 14'h0));
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(ADDR_FLAGS, 32'h28);
    wb(1'b1, ADDR_ENABLE, 32'h10);
    issue(mk(0, 14'h0));
    wait_for(1'b1);
    chk(32'(pc_o), 32'h0088);
    wait_for(1'b0);
    exec(mk(1, 14'h0));
    exec(mk(2, 14'h0));
    chk(32'(gie), 32'h0);
    exec(mk(1, 14'h0));
    exec(mk(0, 14'h0));
    chk(32'(gie), 32'h1);
    exec(mk(2, 14'h0));
    chk(32'(gie), 32'h0);
  endtask : t_block

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_flags;
    t_skip;
    t_pc;
    t_irq;
    t_mask;
    t_block;
    end_of_test;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end
endmodule : visq_sequencer_tb

// >>> verilog/visq_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt sequencer
// Assumes: 14-bit program counter, four vectored sources, 10 MHz clock
// Notes:   Register offsets are byte addresses on a 32-bit Wishbone bus
package visq_pkg;

  // ----------------------------------------------------------------
  // Program counter layout
  // ----------------------------------------------------------------
  localparam int          PC_W          = 14;
  localparam int          OFS_W         = 7;
  localparam logic [13:0] PC_RST        = 14'h0000;
  localparam logic [13:0] PC_ONE        = 14'h0001;
  localparam logic [13:0] VEC_PAGE_BASE = 14'h0080;
  localparam logic [6:0]  VEC_OFS_EXT   = 7'h00;
  localparam logic [6:0]  VEC_OFS_TA    = 7'h04;
  localparam logic [6:0]  VEC_OFS_TB    = 7'h06;
  localparam logic [6:0]  VEC_OFS_TC    = 7'h08;

  // ----------------------------------------------------------------
  // Sources, in priority order
  // ----------------------------------------------------------------
  localparam int         NSRC    = 4;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_TA  = 2'h1;
  localparam logic [1:0] SRC_TB  = 2'h2;
  localparam logic [1:0] SRC_TC  = 2'h3;

  // ----------------------------------------------------------------
  // Enable register fields (first reg in [3:0], second in [7:4])
  // ----------------------------------------------------------------
  localparam int         EN_W       = 8;
  localparam int         EN_EXT_BIT = 0;
  localparam int         EN_TA_BIT  = 2;
  localparam int         EN_TB_BIT  = 3;
  localparam int         EN_TC_BIT  = 4;
  localparam logic [7:0] EN_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Flag register fields
  // ----------------------------------------------------------------
  localparam int FLG_VDROP_BIT = 4;
  localparam int FLG_GLOBAL_IRQ_ENABLE_BIT  = 5;
  localparam int FLG_EIPND_BIT = 6;

  // ----------------------------------------------------------------
  // Wishbone register map
  // ----------------------------------------------------------------
  localparam int         WB_AW        = 8;
  localparam logic [7:0] ADDR_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_FLAGS   = 8'h04;
  localparam logic [7:0] ADDR_PC      = 8'h08;
  localparam logic [7:0] ADDR_CTX     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_MASK    = 8'h14;
  localparam logic [3:0] STATUS_RST   = 4'h0;
  localparam logic [3:0] MASK_RST     = 4'h0;

  // ----------------------------------------------------------------
  // Stack and context
  // ----------------------------------------------------------------
  localparam int         STK_DEPTH = 8;
  localparam int         SP_W      = 3;
  localparam logic [2:0] SP_RST    = 3'h0;
  localparam logic [2:0] SP_ONE    = 3'h1;
  localparam int         DP_W      = 10;
  localparam int         ACC_W     = 4;
  localparam int         CTX_W     = DP_W + 2 + 2 * ACC_W;

  // ----------------------------------------------------------------
  // Timing: system clocks per instruction cycle
  // ----------------------------------------------------------------
  localparam int CLK_HZ    = 10000000;
  localparam int INSTR_DIV = 3;

  typedef struct packed {
    logic [DP_W-1:0]  dp;
    logic             carry_flag;
    logic             skip;
    logic [ACC_W-1:0] acc_a;
    logic [ACC_W-1:0] acc_b;
  } visq_ctx_t;

  typedef struct packed {
    logic            enable_irq_instr;
    logic            disable_irq_instr;
    logic            return_from_irq_instr;
    logic            ret;
    logic            call;
    logic            branch;
    logic            skip_test;
    logic [1:0]      skip_src;
    logic [PC_W-1:0] target;
  } visq_instr_t;

  typedef enum logic [2:0] {
    PH_0 = 3'b001,
    PH_1 = 3'b010,
    PH_2 = 3'b100
  } visq_phase_t;

endpackage : visq_pkg

// >>> verilog/visq_sequencer.sv
// Purpose: Vectored interrupt sequencer and program counter of a 4-bit core
// Assumes: Inputs synchronous to clk_i; one instruction per three clocks
// Notes:   Registers reached over classic Wishbone, 32-bit data
`timescale 1ns/1ns
// Notes on behaviour
// - Take a source only if its flag, its enable and global enable are set.
// - Enable instruction sets global enable; disable instruction clears it.
// - Taking any interrupt clears global enable until enabled again.
// - Enable bit one allows the interrupt and voids the skip test.
// - Request flags set on their event whatever the enables, then hold.
// - A flag still pending is taken as soon as interrupts are enabled.
// - Flags clear when taken or on a valid skip test, except low-voltage.
// - Low-voltage flag cannot clear while its condition persists.
// - Fixed priority: pin, then timer one, two, three.
// - Vector in page one: offsets 0, 4, 6, 8.
// - Taking an interrupt pushes the resume address on the stack.
// - Entry clears only the served source's flag.
// - Entry saves pointer, carry, skip, A and B into the context register.
// - Counter steps one per word unless a jump loads a target or a return pops the stack.
// - Page in upper bits, offset in bits 6..0; offset 127 rolls to next page.
// - Enable instruction acts only after one more instruction completes.
module visq_sequencer
  import visq_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [WB_AW-1:0]        wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Instruction interface
  input  wire logic                    instr_valid_i,
  input  wire visq_pkg::visq_instr_t   instr_i,
  output logic                         instr_ack_o,
  output logic      [PC_W-1:0]         pc_o,
  output logic                         skip_result_o,
  // Context save and restore
  input  wire visq_pkg::visq_ctx_t     ctx_i,
  output visq_pkg::visq_ctx_t          ctx_o,
  output logic                         ctx_restore_o,
  // Event sources
  input  wire logic                    ext_irq_pin_i,
  input  wire logic [2:0]              tmr_uflow_i,
  input  wire logic                    vdrop_cond_i,
  // Status
  output logic                         global_irq_enable_o,
  output logic                         irq_taken_o,
  output logic                         irq_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [1:0] prio_pick(input logic [NSRC-1:0] pend);
    logic [1:0] idx;
    idx = SRC_TC;
    if (pend[SRC_EXT])
    begin
      idx = SRC_EXT;
    end
    else if (pend[SRC_TA])
    begin
      idx = SRC_TA;
    end
    else if (pend[SRC_TB])
    begin
      idx = SRC_TB;
    end
    return idx;
  endfunction : prio_pick

  function automatic logic [PC_W-1:0] vec_of(input logic [1:0] idx);
    logic [6:0] ofs;
    ofs = VEC_OFS_TC;
    if (idx == SRC_EXT)
    begin
      ofs = VEC_OFS_EXT;
    end
    else if (idx == SRC_TA)
    begin
      ofs = VEC_OFS_TA;
    end
    else if (idx == SRC_TB)
    begin
      ofs = VEC_OFS_TB;
    end
    return VEC_PAGE_BASE | {7'h00, ofs};
  endfunction : vec_of

  function automatic logic [NSRC-1:0] onehot_of(input logic [1:0] idx);
    return 4'h1 << idx;
  endfunction : onehot_of

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  visq_phase_t     phase_q;
  visq_phase_t     phase_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;
  logic [NSRC-1:0] flag_q;
  logic [NSRC-1:0] flag_d;
  logic            vdrop_flag_q;
  logic            vdrop_flag_d;
  logic            ext_pin_prev_q;
  logic            global_irq_enable_q;
  logic            global_irq_enable_d;
  logic            ei_pend_q;
  logic            ei_pend_d;
  logic [EN_W-1:0] en_q;
  logic [3:0]      status_q;
  logic [3:0]      status_d;
  logic [3:0]      mask_q;
  logic            skip_q;
  logic            restore_q;
  logic            taken_q;
  visq_ctx_t       ctx_q;
  logic            ack_q;
  logic [31:0]     rdat_q;
  logic [31:0]     rdat_d;

  // ----------------------------------------------------------------
  // Instruction cycle divider
  // ----------------------------------------------------------------
  always_comb
  begin
    case (phase_q)
      PH_0:    phase_d = PH_1;
      PH_1:    phase_d = PH_2;
      PH_2:    phase_d = PH_0;
      default: phase_d = PH_0;
    endcase
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire             step_w    = (phase_q == PH_2) && instr_valid_i;
  wire [NSRC-1:0]  en_src_w  = {en_q[EN_TC_BIT], en_q[EN_TB_BIT],
                                en_q[EN_TA_BIT], en_q[EN_EXT_BIT]};
  wire [NSRC-1:0]  pend_w    = flag_q & en_src_w;
  wire             take_w    = step_w && global_irq_enable_q && (|pend_w);
  wire [1:0]       sel_w     = prio_pick(pend_w);
  wire             exec_w    = step_w && !take_w;
  wire             pop_w     = exec_w && (instr_i.ret || instr_i.return_from_irq_instr);
  wire             call_w    = exec_w && instr_i.call;
  wire             push_w    = take_w || call_w;
  wire             skip_ok_w = exec_w && instr_i.skip_test
                               && !en_src_w[instr_i.skip_src];
  wire [PC_W-1:0]  pc_inc_w  = pc_q + PC_ONE;
  wire [PC_W-1:0]  stk_rd_w;
  wire [PC_W-1:0]  push_dat_w = take_w ? pc_q : pc_inc_w;
  wire [SP_W-1:0]  top_w     = sp_q - SP_ONE;

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  wire [NSRC-1:0]  evt_w     = {tmr_uflow_i,
                                ext_irq_pin_i ^ ext_pin_prev_q};
  wire [NSRC-1:0]  clr_take_w = take_w ? onehot_of(sel_w) : 4'h0;
  wire [NSRC-1:0]  clr_skip_w = skip_ok_w ? onehot_of(instr_i.skip_src) : 4'h0;

  assign flag_d = evt_w | (flag_q & ~(clr_take_w | clr_skip_w));

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire wb_req_w  = wb_cyc_i && wb_stb_i && !ack_q;
  wire wb_wr_w   = wb_req_w && wb_we_i && wb_sel_i[0];
  wire hit_en_w  = (wb_adr_i == ADDR_ENABLE);
  wire hit_flg_w = (wb_adr_i == ADDR_FLAGS);
  wire hit_pc_w  = (wb_adr_i == ADDR_PC);
  wire hit_ctx_w = (wb_adr_i == ADDR_CTX);
  wire hit_st_w  = (wb_adr_i == ADDR_STATUS);
  wire hit_mk_w  = (wb_adr_i == ADDR_MASK);
  wire vdrop_clr_w = wb_wr_w && hit_flg_w && wb_dat_i[FLG_VDROP_BIT];

  assign vdrop_flag_d = vdrop_cond_i || (vdrop_flag_q && !vdrop_clr_w);

  wire [3:0] st_clr_w = (wb_wr_w && hit_st_w) ? wb_dat_i[3:0] : 4'h0;
  assign status_d = clr_take_w | (status_q & ~st_clr_w);

  wire [31:0] flg_rd_w = {25'h0, ei_pend_q, global_irq_enable_q, vdrop_flag_q, flag_q};

  always_comb
  begin
    rdat_d = 32'h00000000;
    if (hit_en_w)
    begin
      rdat_d = {24'h000000, en_q};
    end
    else if (hit_flg_w)
    begin
      rdat_d = flg_rd_w;
    end
    else if (hit_pc_w)
    begin
      rdat_d = {18'h0, pc_q};
    end
    else if (hit_ctx_w)
    begin
      rdat_d = {12'h000, ctx_q};
    end
    else if (hit_st_w)
    begin
      rdat_d = {28'h0000000, status_q};
    end
    else if (hit_mk_w)
    begin
      rdat_d = {28'h0000000, mask_q};
    end
  end

  // ----------------------------------------------------------------
  // Global enable and delayed enable
  // ----------------------------------------------------------------
  always_comb
  begin
    global_irq_enable_d    = global_irq_enable_q;
    ei_pend_d = ei_pend_q;
    if (take_w)
    begin
      global_irq_enable_d = 1'b0;
    end
    else if (exec_w)
    begin
      if (instr_i.disable_irq_instr)
      begin
        global_irq_enable_d    = 1'b0;
        ei_pend_d = 1'b0;
      end
      else if (instr_i.enable_irq_instr)
      begin
        ei_pend_d = 1'b1;
      end
      else if (ei_pend_q)
      begin
        global_irq_enable_d    = 1'b1;
        ei_pend_d = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack pointer
  // ----------------------------------------------------------------
  always_comb
  begin
    pc_d = pc_q;
    sp_d = sp_q;
    if (take_w)
    begin
      pc_d = vec_of(sel_w);
      sp_d = sp_q + SP_ONE;
    end
    else if (exec_w)
    begin
      pc_d = pc_inc_w;
      if (pop_w)
      begin
        pc_d = stk_rd_w;
        sp_d = top_w;
      end
      else if (instr_i.call || instr_i.branch)
      begin
        pc_d = instr_i.target;
        sp_d = call_w ? sp_q + SP_ONE : sp_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Return address stack
  // ----------------------------------------------------------------
  visq_stack_mem u_stack (
    .clk_i   (clk_i),
    .we_i    (push_w),
    .waddr_i (sp_q),
    .wdata_i (push_dat_w),
    .raddr_i (top_w),
    .rdata_o (stk_rd_w)
  );

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q        <= PH_0;
      pc_q           <= PC_RST;
      sp_q           <= SP_RST;
      flag_q         <= 4'h0;
      vdrop_flag_q   <= 1'b0;
      ext_pin_prev_q <= 1'b0;
      global_irq_enable_q         <= 1'b0;
      ei_pend_q      <= 1'b0;
    end
    else
    begin
      phase_q        <= phase_d;
      pc_q           <= pc_d;
      sp_q           <= sp_d;
      flag_q         <= flag_d;
      vdrop_flag_q   <= vdrop_flag_d;
      ext_pin_prev_q <= ext_irq_pin_i;
      global_irq_enable_q         <= global_irq_enable_d;
      ei_pend_q      <= ei_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Skip result, context and entry pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      skip_q    <= 1'b0;
      restore_q <= 1'b0;
      taken_q   <= 1'b0;
      ctx_q     <= '0;
    end
    else
    begin
      restore_q <= exec_w && instr_i.return_from_irq_instr;
      taken_q   <= take_w;
      if (exec_w)
      begin
        skip_q <= skip_ok_w && flag_q[instr_i.skip_src];
      end
      if (take_w)
      begin
        ctx_q <= ctx_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q     <= EN_RST;
      status_q <= STATUS_RST;
      mask_q   <= MASK_RST;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h00000000;
    end
    else
    begin
      ack_q    <= wb_req_w;
      status_q <= status_d;
      if (wb_req_w)
      begin
        rdat_q <= rdat_d;
      end
      if (wb_wr_w && hit_en_w)
      begin
        en_q <= wb_dat_i[7:0];
      end
      if (wb_wr_w && hit_mk_w)
      begin
        mask_q <= wb_dat_i[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign instr_ack_o         = exec_w;
  assign pc_o                = pc_q;
  assign skip_result_o       = skip_q;
  assign ctx_o               = ctx_q;
  assign ctx_restore_o       = restore_q;
  assign global_irq_enable_o = global_irq_enable_q;
  assign irq_taken_o         = taken_q;
  assign irq_o               = |(status_q & mask_q);
  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = rdat_q;

endmodule : visq_sequencer

// >>> verilog/visq_stack_mem.sv
// Purpose: Return address stack storage with registered read data
// Assumes: One write port, one read port, same clock
// Notes:   Overflow wraps and overwrites the oldest entry
`timescale 1ns/1ns
module visq_stack_mem
  import visq_pkg::*;
(
  // Clock
  input  wire logic                 clk_i,
  // Write port
  input  wire logic                 we_i,
  input  wire logic [SP_W-1:0]      waddr_i,
  input  wire logic [PC_W-1:0]      wdata_i,
  // Read port
  input  wire logic [SP_W-1:0]      raddr_i,
  output logic      [PC_W-1:0]      rdata_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [PC_W-1:0] mem_q [STK_DEPTH];
  logic [PC_W-1:0] rdata_q;

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_q <= mem_q[raddr_i];
  end

  assign rdata_o = rdata_q;

endmodule : visq_stack_mem
